//--- design/phys_filter_pkg.sv
package phys_filter_pkg;
  // register byte addresses
  localparam logic [11:0] OFS_HIGH_SET  = 12'h110;
  localparam logic [11:0] OFS_HIGH_CLR  = 12'h114;
  localparam logic [11:0] OFS_LOW_SET   = 12'h118;
  localparam logic [11:0] OFS_LOW_CLR   = 12'h11C;
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;

  // reset values
  localparam logic [31:0] RST_LOW       = 32'h0000_0000;
  localparam logic [31:0] RST_HIGH      = 32'h0000_0000;

  // high register fields
  localparam int          REMOTE_BIT    = 31;
  localparam int          NODE_HIGH_BASE = 32;
  // a host bus reset clears every high bit except the remote-bus enable
  localparam logic [31:0] HOST_RST_HIGH_MASK = 32'h7FFF_FFFF;
  localparam logic [31:0] HOST_RST_LOW_MASK  = 32'hFFFF_FFFF;

  // source identifier layout
  localparam int          NODE_W        = 6;
  localparam int          BUS_W         = 10;
  localparam logic [5:0]  NODE_BCAST    = 6'h3F;
  localparam logic [9:0]  BUS_LOCAL_ALIAS = 10'h3FF;

  // axi responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : phys_filter_pkg

//--- design/physical_request_node_filter.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module physical_request_node_filter
  import phys_filter_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              host_bus_reset,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // incoming physical request from link core
  input  wire logic              req_valid,
  input  wire logic [15:0]       req_source_id,
  input  wire logic              req_async_pass,
  input  wire logic [BUS_W-1:0]  local_bus_id,
  // routing decision, one pulse per request
  output logic                   route_phys_r,
  output logic                   route_async_r,
  output logic                   route_reject_r
);

  // write and read channel holding state
  logic              aw_held_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic              w_held_r;
  logic [DATA_W-1:0] w_data_r;
  logic [3:0]        w_strb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0]        rresp_r;

  logic              do_write;
  logic [31:0]       wr_ones;
  logic [31:0]       low_set;
  logic [31:0]       low_clr;
  logic [31:0]       high_set;
  logic [31:0]       high_clr;
  logic [31:0]       low_soft;
  logic [31:0]       high_soft;
  logic [31:0]       low_q;
  logic [31:0]       high_q;
  logic              wr_mapped;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  assign do_write = aw_held_r && w_held_r && !bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  // only bytes enabled by the strobes can carry ones
  always_comb begin
    wr_ones = w_data_r & {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                          {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  end

  always_comb begin
    wr_mapped = (aw_addr_r == OFS_HIGH_SET) || (aw_addr_r == OFS_HIGH_CLR) ||
                (aw_addr_r == OFS_LOW_SET)  || (aw_addr_r == OFS_LOW_CLR);
  end

  // zeros in the data produce zero masks, so those bits stay put
  assign low_set  = (do_write && aw_addr_r == OFS_LOW_SET)  ? wr_ones : '0;
  assign low_clr  = (do_write && aw_addr_r == OFS_LOW_CLR)  ? wr_ones : '0;
  assign high_set = (do_write && aw_addr_r == OFS_HIGH_SET) ? wr_ones : '0;
  assign high_clr = (do_write && aw_addr_r == OFS_HIGH_CLR) ? wr_ones : '0;

  // host bus reset spares the remote-bus enable
  assign low_soft  = host_bus_reset ? HOST_RST_LOW_MASK  : '0;
  assign high_soft = host_bus_reset ? HOST_RST_HIGH_MASK : '0;

  set_clear_reg #(
    .RST_VAL       (RST_LOW)
  ) u_low (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .set_mask      (low_set),
    .clr_mask      (low_clr),
    .soft_clr_mask (low_soft),
    .value_r       (low_q)
  );

  set_clear_reg #(
    .RST_VAL       (RST_HIGH)
  ) u_high (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .set_mask      (high_set),
    .clr_mask      (high_clr),
    .soft_clr_mask (high_soft),
    .value_r       (high_q)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // both offsets of a pair read back the live value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      case (s_axi_araddr)
        OFS_HIGH_SET, OFS_HIGH_CLR: begin
          rdata_r <= high_q;
          rresp_r <= RESP_OKAY;
        end
        OFS_LOW_SET, OFS_LOW_CLR: begin
          rdata_r <= low_q;
          rresp_r <= RESP_OKAY;
        end
        default: begin
          rdata_r <= '0;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // routing decision
  logic [NODE_W-1:0] src_node;
  logic [BUS_W-1:0]  src_bus;
  logic              src_local;
  logic [63:0]       node_map;
  logic              node_enabled;

  assign src_node = req_source_id[NODE_W-1:0];
  assign src_bus  = req_source_id[15:NODE_W];
  // bus id all ones also names the local bus
  assign src_local = (src_bus == local_bus_id) || (src_bus == BUS_LOCAL_ALIAS);

  // node n -> low bit n, node k+32 -> high bit k
  assign node_map = {high_q, low_q};

  // the broadcast node has no filter bit; index 63 would alias the remote enable
  assign node_enabled = (src_node != NODE_BCAST) && node_map[src_node];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_phys_r   <= 1'b0;
      route_async_r  <= 1'b0;
      route_reject_r <= 1'b0;
    end else begin
      route_phys_r   <= 1'b0;
      route_async_r  <= 1'b0;
      route_reject_r <= 1'b0;
      if (req_valid) begin
        if (!src_local) begin
          // remote sources skip node compare gated by remote enable
          route_phys_r   <= high_q[REMOTE_BIT];
          route_reject_r <= !high_q[REMOTE_BIT];
        end else if (!req_async_pass) begin
          route_reject_r <= 1'b1;
        end else if (node_enabled) begin
          route_phys_r   <= 1'b1;
        end else begin
          route_async_r  <= 1'b1;
        end
      end
    end
  end

endmodule : physical_request_node_filter

//--- design/set_clear_reg.sv
`timescale 1ns/1ps
module set_clear_reg
  import phys_filter_pkg::*;
#(
  parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // update masks
  input  wire logic [31:0] set_mask,
  input  wire logic [31:0] clr_mask,
  input  wire logic [31:0] soft_clr_mask,
  // value
  output logic      [31:0] value_r
);

  logic [31:0] value_nxt;

  // only one bits act; set wins over any clear in the same cycle
  always_comb begin
    value_nxt = (value_r & ~(clr_mask | soft_clr_mask)) | set_mask;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_r <= RST_VAL;
    end else begin
      value_r <= value_nxt;
    end
  end

endmodule : set_clear_reg

//--- verification/physical_request_node_filter_monitor.sv
`timescale 1ns/1ps
module physical_request_node_filter_monitor
  import phys_filter_pkg::*;
(
  // clock and reset
  input logic        aclk,
  input logic        aresetn,
  // register bus
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_awready,
  input logic        s_axi_wready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  // requests
  input logic        req_valid,
  input logic [15:0] req_source_id,
  input logic        req_async_pass,
  input logic [9:0]  local_bus_id,
  input logic        route_phys_r,
  input logic        route_async_r,
  input logic        route_reject_r
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire       lcl = (req_source_id[15:6] == local_bus_id) ||
                   (req_source_id[15:6] == BUS_LOCAL_ALIAS);
  wire [2:0] rt  = {route_phys_r, route_async_r, route_reject_r};
  sequence s_local_req;
    req_valid && lcl && req_async_pass;
  endsequence
  a_route_onehot: assert property (
    req_valid |=> $onehot(rt)) else $error("route not one-hot");
  a_route_idle: assert property (
    !req_valid |=> rt == 3'h0) else $error("route without request");
  a_remote_skip: assert property (
    req_valid && !lcl |=> !route_async_r) else $error("remote source sent async");
  a_async_first: assert property (
    req_valid && lcl && !req_async_pass |=> route_reject_r) else $error("async filter skipped");
  a_bcast_async: assert property (
    s_local_req ##0 req_source_id[5:0] == NODE_BCAST |=> route_async_r) else $error("bcast route");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("b dropped");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("r dropped");
  // one write at a time: no new address or data while a response waits
  a_write_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken during b");
  a_read_block: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken during r");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
endmodule : physical_request_node_filter_monitor
bind physical_request_node_filter physical_request_node_filter_monitor mon_inst (.aclk, .aresetn,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_awready, .s_axi_wready,
  .s_axi_rready, .s_axi_rdata, .req_valid, .req_source_id, .req_async_pass, .local_bus_id,
  .route_phys_r, .route_async_r, .route_reject_r);

//--- verification/req_source_model.sv
`timescale 1ns/1ps
module req_source_model (
  // clock
  input  logic        aclk,
  // request to filter
  output logic        req_valid = 1'h0,
  output logic [15:0] req_source_id = 16'h0,
  output logic        req_async_pass = 1'h0,
  // routing answer
  input  logic        route_phys_r,
  input  logic        route_async_r,
  input  logic        route_reject_r
);
  task send(input logic [9:0] b, input logic [5:0] n, input logic p, output logic [2:0] rt);
    @(posedge aclk);
    req_valid <= 1'h1;
    req_source_id <= {b, n};
    req_async_pass <= p;
    @(posedge aclk);
    req_valid <= 1'h0;
    // stale id inverted so nothing leans on a held value
    req_source_id <= ~{b, n};
    req_async_pass <= ~p;
    #1 rt = {route_phys_r, route_async_r, route_reject_r};
  endtask : send
endmodule : req_source_model

//--- verification/tb_physical_request_node_filter.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module tb_physical_request_node_filter
  import phys_filter_pkg::*;
;
  logic        aclk = 1'h0, aresetn = 1'h0, host_bus_reset = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        req_valid, req_async_pass, route_phys_r, route_async_r, route_reject_r;
  logic [15:0] req_source_id;
  logic [9:0]  local_bus_id = 10'h155;
  logic [31:0] d;
  logic [2:0]  rt;
  int          err_count = 0, total_checks = 0;
  physical_request_node_filter physical_request_node_filter_inst (.aclk, .aresetn,
    .host_bus_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .req_valid, .req_source_id, .req_async_pass, .local_bus_id, .route_phys_r, .route_async_r,
    .route_reject_r);
  req_source_model req_source_model_inst (.aclk, .req_valid, .req_source_id, .req_async_pass,
    .route_phys_r, .route_async_r, .route_reject_r);
  initial forever #4 aclk = ~aclk;
  task conclude;
    $display("errors %0d checks %0d", err_count, total_checks);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  task chk_rd(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    `CHK("rdata", e, d)
  endtask : chk_rd
  task rte(input logic [9:0] b, input logic [5:0] n, input logic p, input logic [2:0] e);
    req_source_model_inst.send(b, n, p, rt);
    `CHK("route", e, rt)
  endtask : rte
  task t_regs;
    chk_rd(OFS_LOW_SET, 32'h0);
    chk_rd(OFS_HIGH_CLR, 32'h0);
    wr(OFS_LOW_SET, 32'hA5A5_0F0F);
    `CHK("bresp", RESP_OKAY, r)
    chk_rd(OFS_LOW_CLR, 32'hA5A5_0F0F);
    wr(OFS_LOW_SET, 32'h0);
    wr(OFS_LOW_CLR, 32'h0000_0F00);
    chk_rd(OFS_LOW_SET, 32'hA5A5_000F);
    wr(OFS_HIGH_SET, 32'h1234_5678);
    chk_rd(OFS_HIGH_CLR, 32'h1234_5678);
    wr(OFS_HIGH_CLR, 32'hFFFF_FFFF);
    wr(OFS_LOW_CLR, 32'hFFFF_FFFF);
    chk_rd(OFS_HIGH_SET, 32'h0);
    wr(12'h120, 32'hFFFF_FFFF);
    `CHK("bresp", RESP_SLVERR, r)
    rd(12'h120);
    `CHK("rresp", RESP_SLVERR, r)
    `CHK("rdata", 32'h0, d)
  endtask : t_regs
  task t_nodes;
    logic [63:0] f;
    f = {32'h400C_0001, 32'h8000_0001};
    wr(OFS_LOW_SET, f[31:0]);
    wr(OFS_HIGH_SET, f[63:32]);
    // node 63 is broadcast and has no enable bit
    for (int n = 0; n < 64; n++) begin
      rte(local_bus_id, n[5:0], 1'h1, (n != 63 && f[n]) ? 3'h4 : 3'h2);
    end
    rte(local_bus_id, 6'h0, 1'h0, 3'h1);
    rte(local_bus_id, 6'h1, 1'h1, 3'h2);
    // all-ones bus id names the local bus, so the node compare applies
    rte(10'h3FF, 6'h0, 1'h1, 3'h4);
    rte(10'h3FF, 6'h1, 1'h1, 3'h2);
  endtask : t_nodes
  task t_remote;
    rte(10'h0AA, 6'h0, 1'h1, 3'h1);
    wr(OFS_HIGH_SET, 32'h8000_0000);
    rte(10'h0AA, 6'h5, 1'h1, 3'h4);
    @(posedge aclk);
    host_bus_reset <= 1'h1;
    @(posedge aclk);
    host_bus_reset <= 1'h0;
    chk_rd(OFS_HIGH_SET, 32'h8000_0000);
    chk_rd(OFS_LOW_SET, 32'h0);
  endtask : t_remote
  initial begin
    #100000;
    err_count++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_nodes();
    t_remote();
    conclude();
  end
endmodule : tb_physical_request_node_filter
